// file: packet_header_and_starve_irq.sv
`timescale 1ns/1ps
// Operation
// - Eight read-only starvation bits, one per DMA channel, set on starvation.
// - Writing the clear field zeroes the selected starvation bits.
// - Writing the force field sets the selected starvation bits.
// - Four-bit processor mask per channel routes starvation interrupts.
// - First 64 bits: global header; upper 64 bits: local header.
// - Word 0 bits 29..24 hold the flow index.
// - Word 0 bits 23..16 hold total header length in words.
// - Word 0 bits 10..8 select LTE, WiMAX or WCDMA.
// - Halt bit stops softly when idle and interrupts until cleared.
// - Drop bit discards the packet.
// - Flush bit blocks the queue until write-back finishes.
// - Word 0 bits 1..0 give single, start, middle or end type.
// - Global word 1 logged on finish; low half is destination tag.
// - Local word 0 holds module identifier and local length.
// - Local word 1 bits 8..4 count info quad-words, at most 31.
// - Local word 1 bits 3..0 count protocol words, zero to eight.
// - Optional protocol and info data span local words 2 to 133.
// - Each new error bit is logged unless a tag is logged in the same cycle, and raises an enabled error interrupt.
// - Error bit 7 flags DMA descriptor starvation.
// - Error bit 6 flags first module identifier 14 or 15.
// - Error bits 4 and 5 flag missing start and missing end.
// - Error bit 3 flags start or middle last beat not 0x10.
module packet_header_and_starve_irq
  import hdr_pkg::*;
(
  input  wire logic         CLOCK_IN,
  input  wire logic         RST_IN,
  input  wire logic [7:0]   ADDR_IN,
  input  wire logic [31:0]  WDATA_IN,
  input  wire logic         WR_IN,
  input  wire logic         RD_IN,
  output logic      [31:0]  RDATA_OUT,
  input  wire logic         SOP_IN,
  input  wire logic         EOP_IN,
  input  wire logic [127:0] WORD_IN,
  input  wire logic [4:0]   LAST_BYTES_IN,
  input  wire logic         TX_IDLE_IN,
  input  wire logic         WRITEBACK_DONE_IN,
  input  wire logic [7:0]   STARVE_IN,
  output logic              ACCEPT_OUT,
  output logic              DROP_OUT,
  output logic              HALTED_OUT,
  output logic [5:0]        FLOW_INDEX_OUT,
  output logic [15:0]       DEST_TAG_OUT,
  output logic              LOG_WRITE_OUT,
  output logic [31:0]       LOG_DATA_OUT,
  output logic [3:0]        STARVE_IRQ_OUT,
  output logic              HALT_IRQ_OUT,
  output logic              ERROR_IRQ_OUT
);

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DRAIN = 3'b010,
    ST_HALT  = 3'b100
  } run_t;

  typedef struct packed {
    run_t        run;
    logic [7:0]  starve;
    logic [31:0] routing;
    logic        halt_mask;
    logic        error_enable;
    logic        log_enable;
    logic        flushing;
    logic        in_packet;
    logic        in_sequence;
    logic [1:0]  cur_type;
    logic        cur_drop;
    logic [7:0]  errors;
    logic [31:0] tag;
    logic [5:0]  flow;
    logic [2:0]  radio;
    logic [7:0]  hdr_len;
    logic [3:0]  modid;
    logic [7:0]  local_len;
    logic [4:0]  info_cnt;
    logic [3:0]  ps_cnt;
    logic        local_bad;
    logic [31:0] rdata;
    logic        log_write;
    logic [31:0] log_data;
    logic [3:0]  starve_irq;
    logic        halt_irq;
    logic        error_irq;
    logic        accept;
    logic        halted;
    logic        eop_seen;
    logic [4:0]  last_bytes;
  } core_t;

  core_t s_reg;
  core_t s_next;

  logic [7:0] starve_sync1_reg;
  logic [7:0] starve_sync2_reg;
  logic [7:0] starve_prev_reg;
  logic [3:0] route_hits;
  logic [7:0] new_err;
  logic [3:0] chan_mask [8];

  hdr_if hdr ();

  hdr_parser u_parser (
    .clk_in  (CLOCK_IN),
    .rst_in  (RST_IN),
    .sop_in  (SOP_IN),
    .word_in (WORD_IN),
    .hdr     (hdr)
  );

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      starve_sync1_reg <= 8'h00;
      starve_sync2_reg <= 8'h00;
      starve_prev_reg  <= 8'h00;
    end else begin
      starve_sync1_reg <= STARVE_IN;
      starve_sync2_reg <= starve_sync1_reg;
      starve_prev_reg  <= starve_sync2_reg;
    end
  end

  for (genvar ch = 0; ch < 8; ch++) begin : g_route
    assign chan_mask[ch] = s_reg.starve[ch] ? s_reg.routing[4*ch +: 4]
                                            : 4'h0;
  end

  always_comb begin
    route_hits = 4'h0;
    for (int ch = 0; ch < 8; ch++) begin
      route_hits = route_hits | chan_mask[ch];
    end
  end

  always_comb begin
    s_next = s_reg;
    new_err = 8'h00;
    s_next.log_write = 1'b0;
    s_next.rdata = RESET_WORD;

    if (WR_IN && ADDR_IN == OFF_STARVE_CLEAR) begin
      s_next.starve = s_next.starve & ~WDATA_IN[7:0];
    end
    if (WR_IN && ADDR_IN == OFF_STARVE_FORCE) begin
      s_next.starve = s_next.starve | WDATA_IN[7:0];
    end
    s_next.starve = s_next.starve | (starve_sync2_reg & ~starve_prev_reg);
    if ((starve_sync2_reg & ~starve_prev_reg) != 8'h00) begin
      new_err[ERR_STARVE] = 1'b1;
    end

    if (WR_IN && ADDR_IN == OFF_IRQ_ROUTING) begin
      s_next.routing = WDATA_IN;
    end
    if (WR_IN && ADDR_IN == OFF_CONTROL) begin
      s_next.halt_mask = WDATA_IN[1];
      s_next.error_enable = WDATA_IN[2];
      s_next.log_enable = WDATA_IN[3];
      if (WDATA_IN[0]) begin
        s_next.run = ST_RUN;
        s_next.halt_irq = 1'b0;
      end
    end
    if (WR_IN && ADDR_IN == OFF_ERROR_STATUS) begin
      s_next.errors = s_next.errors & ~WDATA_IN[7:0];
    end

    if (hdr.valid) begin
      s_next.flow = hdr.flow_index;
      s_next.radio = hdr.radio;
      s_next.hdr_len = hdr.header_word_count;
      s_next.modid = hdr.submodule_identifier;
      s_next.local_len = hdr.local_header_words;
      s_next.info_cnt = hdr.info_count;
      s_next.ps_cnt = hdr.protocol_word_count;
      s_next.tag = hdr.logger_tag_word;
      s_next.cur_type = hdr.pkt_type;
      s_next.in_packet = 1'b1;
      s_next.cur_drop = hdr.drop;
      s_next.local_bad = (hdr.protocol_word_count > PS_MAX)
                       || (hdr.local_header_words > LOCAL_MAX_WORD);
      if (hdr.flush) begin
        s_next.flushing = 1'b1;
      end
      if (hdr.halt && s_reg.run == ST_RUN) begin
        s_next.run = ST_DRAIN;
      end
      if (hdr.submodule_identifier == MODID_BAD_A
          || hdr.submodule_identifier == MODID_BAD_B) begin
        new_err[ERR_ROUTE] = 1'b1;
      end

      case (hdr.pkt_type)
        PT_SINGLE: begin
          if (s_reg.in_sequence) begin
            new_err[ERR_NO_EOM] = 1'b1;
          end
          s_next.in_sequence = 1'b0;
        end
        PT_START: begin
          if (s_reg.in_sequence) begin
            new_err[ERR_NO_EOM] = 1'b1;
          end
          s_next.in_sequence = 1'b1;
        end
        PT_MIDDLE, PT_END: begin
          if (!s_reg.in_sequence) begin
            new_err[ERR_NO_SOM] = 1'b1;
          end
          s_next.in_sequence = (hdr.pkt_type == PT_MIDDLE);
        end
        default: begin
          s_next.in_sequence = 1'b0;
        end
      endcase
    end

    // The end mark waits one register so that it meets the header that
    // the parser holds back by one cycle; a header beside it opens a
    // new packet.
    s_next.eop_seen = EOP_IN;
    s_next.last_bytes = LAST_BYTES_IN;
    if (s_reg.eop_seen && s_reg.in_packet) begin
      s_next.in_packet = hdr.valid;
      if ((s_reg.cur_type == PT_START || s_reg.cur_type == PT_MIDDLE)
          && s_reg.last_bytes != LAST_BEAT_FULL) begin
        new_err[ERR_XCNT] = 1'b1;
      end
      if (s_reg.log_enable && !s_reg.cur_drop) begin
        s_next.log_write = 1'b1;
        s_next.log_data = s_reg.tag;
      end
    end

    if (WRITEBACK_DONE_IN) begin
      s_next.flushing = 1'b0;
    end

    case (s_reg.run)
      ST_RUN: begin
      end
      ST_DRAIN: begin
        if (TX_IDLE_IN && !s_reg.in_packet) begin
          s_next.run = ST_HALT;
          s_next.halt_irq = !s_reg.halt_mask;
        end
      end
      ST_HALT: begin
      end
      default: begin
        s_next.run = ST_RUN;
      end
    endcase

    s_next.accept = (s_next.run == ST_RUN) && !s_next.flushing;
    s_next.halted = (s_next.run == ST_HALT);

    s_next.errors = s_next.errors | new_err;
    if (s_reg.log_enable && new_err != 8'h00 && !s_next.log_write) begin
      s_next.log_write = 1'b1;
      s_next.log_data = {24'h00_0000, new_err};
    end
    s_next.error_irq = s_reg.error_enable && (s_next.errors != 8'h00);
    s_next.starve_irq = route_hits;

    if (RD_IN) begin
      case (ADDR_IN)
        OFF_STARVE_STATUS: s_next.rdata = {24'h00_0000, s_reg.starve};
        OFF_IRQ_ROUTING:   s_next.rdata = s_reg.routing;
        OFF_CONTROL: begin
          s_next.rdata = {25'h000_0000, s_reg.run, s_reg.log_enable,
                          s_reg.error_enable, s_reg.halt_mask, 1'b0};
        end
        OFF_ERROR_STATUS:  s_next.rdata = {24'h00_0000, s_reg.errors};
        OFF_PKT_INFO: begin
          s_next.rdata = {2'h0, s_reg.flow, s_reg.hdr_len, 5'h00,
                          s_reg.radio, s_reg.local_bad, s_reg.flushing,
                          s_reg.in_sequence, s_reg.cur_drop,
                          s_reg.in_packet, 1'b0, s_reg.cur_type};
        end
        OFF_LOGGER_TAG:    s_next.rdata = s_reg.tag;
        OFF_LOCAL_INFO: begin
          s_next.rdata = {7'h00, s_reg.info_cnt, s_reg.ps_cnt,
                          s_reg.modid, s_reg.local_len, 4'h0};
        end
        default:           s_next.rdata = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_reg <= '0;
      s_reg.run <= ST_RUN;
      s_reg.accept <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA_OUT = s_reg.rdata;
  assign ACCEPT_OUT = s_reg.accept;
  assign DROP_OUT = s_reg.cur_drop;
  assign HALTED_OUT = s_reg.halted;
  assign FLOW_INDEX_OUT = s_reg.flow;
  assign DEST_TAG_OUT = s_reg.tag[15:0];
  assign LOG_WRITE_OUT = s_reg.log_write;
  assign LOG_DATA_OUT = s_reg.log_data;
  assign STARVE_IRQ_OUT = s_reg.starve_irq;
  assign HALT_IRQ_OUT = s_reg.halt_irq;
  assign ERROR_IRQ_OUT = s_reg.error_irq;
endmodule : packet_header_and_starve_irq

// file: hdr_pkg.sv
// Package of constants and types for the packet header front end.
package hdr_pkg;
  localparam logic [7:0] OFF_STARVE_STATUS = 8'h00;
  localparam logic [7:0] OFF_STARVE_CLEAR  = 8'h04;
  localparam logic [7:0] OFF_STARVE_FORCE  = 8'h08;
  localparam logic [7:0] OFF_IRQ_ROUTING   = 8'h0C;
  localparam logic [7:0] OFF_CONTROL       = 8'h10;
  localparam logic [7:0] OFF_ERROR_STATUS  = 8'h14;
  localparam logic [7:0] OFF_PKT_INFO      = 8'h18;
  localparam logic [7:0] OFF_LOGGER_TAG    = 8'h1C;
  localparam logic [7:0] OFF_LOCAL_INFO    = 8'h20;
  localparam int FLOW_HI = 29;
  localparam int FLOW_LO = 24;
  localparam int HLEN_HI = 23;
  localparam int HLEN_LO = 16;
  localparam int RADIO_HI = 10;
  localparam int RADIO_LO = 8;
  localparam int HALT_BIT = 5;
  localparam int DROP_BIT = 4;
  localparam int FLUSH_BIT = 3;
  localparam int MODID_HI = 11;
  localparam int MODID_LO = 8;
  localparam int INFO_HI = 8;
  localparam int INFO_LO = 4;
  localparam int PSW_HI = 3;
  localparam int PSW_LO = 0;
  localparam int ERR_STARVE = 7;
  localparam int ERR_ROUTE = 6;
  localparam int ERR_NO_EOM = 5;
  localparam int ERR_NO_SOM = 4;
  localparam int ERR_XCNT = 3;
  localparam logic [3:0] MODID_BAD_A = 4'hE;
  localparam logic [3:0] MODID_BAD_B = 4'hF;
  localparam logic [4:0] LAST_BEAT_FULL = 5'h10;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic [7:0] LOCAL_MAX_WORD = 8'h85;
  localparam logic [2:0] RADIO_LTE = 3'h0;
  localparam logic [2:0] RADIO_WIMAX = 3'h2;
  localparam logic [2:0] RADIO_WCDMA = 3'h4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    PT_SINGLE = 2'h0, PT_START = 2'h1, PT_MIDDLE = 2'h2, PT_END = 2'h3
  } pkt_type_t;
endpackage : hdr_pkg

// file: hdr_if.sv
`timescale 1ns/1ps
// Interface carrying parsed header fields from parser to core.
interface hdr_if;
  logic        valid;
  logic [5:0]  flow_index;
  logic [7:0]  header_word_count;
  logic [2:0]  radio;
  logic        halt;
  logic        drop;
  logic        flush;
  logic [1:0]  pkt_type;
  logic [31:0] logger_tag_word;
  logic [3:0]  submodule_identifier;
  logic [7:0]  local_header_words;
  logic [4:0]  info_count;
  logic [3:0]  protocol_word_count;
  modport src (output valid, flow_index, header_word_count, radio, halt,
               drop, flush, pkt_type, logger_tag_word, submodule_identifier,
               local_header_words, info_count, protocol_word_count);
  modport dst (input valid, flow_index, header_word_count, radio, halt,
               drop, flush, pkt_type, logger_tag_word, submodule_identifier,
               local_header_words, info_count, protocol_word_count);
endinterface : hdr_if

// file: hdr_parser.sv
`timescale 1ns/1ps
// Splits the first 128-bit word of a packet into header fields.
module hdr_parser
  import hdr_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         sop_in,
  input  wire logic [127:0] word_in,
  hdr_if.src                hdr
);
  typedef struct packed {
    logic        valid;
    logic [127:0] word;
  } parse_state_t;
  parse_state_t state_reg;
  parse_state_t state_next;
  always_comb begin
    state_next = state_reg;
    state_next.valid = sop_in;
    if (sop_in) begin
      state_next.word = word_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign hdr.valid = state_reg.valid;
  assign hdr.flow_index = state_reg.word[FLOW_HI:FLOW_LO];
  assign hdr.header_word_count = state_reg.word[HLEN_HI:HLEN_LO];
  assign hdr.radio = state_reg.word[RADIO_HI:RADIO_LO];
  assign hdr.halt = state_reg.word[HALT_BIT];
  assign hdr.drop = state_reg.word[DROP_BIT];
  assign hdr.flush = state_reg.word[FLUSH_BIT];
  assign hdr.pkt_type = state_reg.word[1:0];
  assign hdr.logger_tag_word = state_reg.word[63:32];
  assign hdr.submodule_identifier = state_reg.word[64+MODID_HI:64+MODID_LO];
  assign hdr.local_header_words = state_reg.word[71:64];
  assign hdr.info_count = state_reg.word[96+INFO_HI:96+INFO_LO];
  assign hdr.protocol_word_count = state_reg.word[96+PSW_HI:96+PSW_LO];
endmodule : hdr_parser

// file: hdr_starve_monitor.sv
// Checker of register and header behaviour at the block's ports.
`timescale 1ns/1ps
module hdr_starve_monitor
  import hdr_pkg::*;
(
  input wire logic         CLOCK_IN,
  input wire logic         RST_IN,
  input wire logic [7:0]   ADDR_IN,
  input wire logic [31:0]  WDATA_IN,
  input wire logic         WR_IN,
  input wire logic         RD_IN,
  input wire logic [31:0]  RDATA_OUT,
  input wire logic         SOP_IN,
  input wire logic [127:0] WORD_IN,
  input wire logic         ACCEPT_OUT,
  input wire logic         DROP_OUT,
  input wire logic         HALTED_OUT,
  input wire logic [5:0]   FLOW_INDEX_OUT,
  input wire logic [15:0]  DEST_TAG_OUT
);
  logic wr_force;
  logic wr_clr;
  logic rd_stat;
  logic take;
  logic rel;
  assign wr_force = WR_IN && ADDR_IN == OFF_STARVE_FORCE;
  assign wr_clr   = WR_IN && ADDR_IN == OFF_STARVE_CLEAR;
  assign rd_stat  = RD_IN && ADDR_IN == OFF_STARVE_STATUS;
  assign take     = SOP_IN && ACCEPT_OUT;
  assign rel      = WR_IN && ADDR_IN == OFF_CONTROL && WDATA_IN[0];
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RST_IN);
  chk_read_idle : assert property (
    !$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_stat_reserved : assert property (
    rd_stat |=> RDATA_OUT[31:8] == 24'h00_0000)
    else $error("status upper bits not zero");
  chk_force_sets : assert property (
    wr_force ##1 rd_stat |=> (RDATA_OUT[7:0] & $past(WDATA_IN[7:0], 2))
    == $past(WDATA_IN[7:0], 2)) else $error("forced bits not set");
  chk_clear_zeros : assert property (
    wr_clr ##1 rd_stat |=> (RDATA_OUT[7:0] & $past(WDATA_IN[7:0], 2))
    == 8'h00) else $error("cleared bits still set");
  chk_flow_index : assert property (
    take |-> ##2 FLOW_INDEX_OUT == $past(WORD_IN[FLOW_HI:FLOW_LO], 2))
    else $error("flow index wrong");
  chk_dest_tag : assert property (
    take |-> ##2 DEST_TAG_OUT == $past(WORD_IN[47:32], 2))
    else $error("destination tag wrong");
  chk_drop_flag : assert property (
    take |-> ##2 DROP_OUT == $past(WORD_IN[DROP_BIT], 2))
    else $error("drop flag wrong");
  chk_flush_block : assert property (
    take && WORD_IN[FLUSH_BIT] |-> ##2 !ACCEPT_OUT)
    else $error("flush did not stop acceptance");
  chk_halt_hold : assert property (
    HALTED_OUT && !rel |=> HALTED_OUT) else $error("halt left early");
  chk_halt_stop : assert property (
    HALTED_OUT |-> !ACCEPT_OUT) else $error("accepting while halted");
  cover property (wr_force ##1 rd_stat);
  cover property ($rose(HALTED_OUT));
  cover property (take && WORD_IN[FLUSH_BIT]);
endmodule : hdr_starve_monitor
bind packet_header_and_starve_irq hdr_starve_monitor mon (.*);

// file: packet_dma_partner.sv
// Behavioural packet DMA engine that feeds packets to the front end.
`timescale 1ns/1ps
module packet_dma_partner (
  input  wire logic    clk_in,
  output logic         sop_out,
  output logic         eop_out,
  output logic [127:0] word_out,
  output logic [4:0]   last_bytes_out,
  output logic         tx_idle_out,
  output logic         wb_done_out,
  output logic [7:0]   starve_out
);
  initial begin
    sop_out = 1'b0;
    eop_out = 1'b0;
    word_out = '0;
    last_bytes_out = 5'h00;
    tx_idle_out = 1'b1;
    wb_done_out = 1'b0;
    starve_out = 8'h00;
  end
  function automatic logic [127:0] mk(input logic [5:0] fl,
    input logic [2:0] ra, input logic [2:0] hdf, input logic [1:0] ty,
    input logic [31:0] tg, input logic [3:0] md);
    mk = {32'h0000_0000, 20'h0_0000, md, 8'h01, tg, 2'h0, fl, 8'h04,
          5'h00, ra, 2'h0, hdf, 1'h0, ty};
  endfunction : mk
  task automatic send(input logic [127:0] w, input logic [4:0] lb);
    @(posedge clk_in);
    sop_out <= 1'b1;
    word_out <= w;
    tx_idle_out <= 1'b0;
    @(posedge clk_in);
    sop_out <= 1'b0;
    eop_out <= 1'b1;
    last_bytes_out <= lb;
    word_out <= ~w;
    @(posedge clk_in);
    eop_out <= 1'b0;
    last_bytes_out <= ~lb;
    tx_idle_out <= 1'b1;
  endtask : send
  task automatic wb_done(input int n);
    repeat (n) @(posedge clk_in);
    wb_done_out <= 1'b1;
    @(posedge clk_in);
    wb_done_out <= 1'b0;
  endtask : wb_done
  task automatic starve(input int ch);
    @(posedge clk_in);
    starve_out[ch] <= 1'b1;
  endtask : starve
endmodule : packet_dma_partner

// file: packet_header_and_starve_irq_bench.sv
// Self-checking bench for the packet header and starvation block.
`timescale 1ns/1ps
module packet_header_and_starve_irq_bench;
  import hdr_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wd = 32'h0000_0000;
  logic [31:0]  seed = 32'h0000_E366;
  logic [31:0]  rdata, v, last_log, logd;
  logic         sop, eop, idle, wbd, accept, drop, halted, logw, hirq, eirq;
  logic [127:0] word;
  logic [4:0]   lb;
  logic [7:0]   starve;
  logic [5:0]   flow;
  logic [15:0]  dtag;
  logic [3:0]   sirq;
  int           mismatches = 0, n_checks = 0, st_m = 0, rt_m, m, tg;
  logic [2:0]   radio [4] = '{RADIO_LTE, RADIO_WIMAX, RADIO_WCDMA, RADIO_LTE};
  logic [1:0]   e_ty [5] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [3:0]   e_md [5] = '{4'hE, 4'hF, 4'h1, 4'h1, 4'h1};
  logic [4:0]   e_lb [5] = '{5'h10, 5'h10, 5'h10, 5'h08, 5'h10};
  // A start after an orphan middle also finds the earlier end missing.
  int e_err [5] = '{1 << ERR_ROUTE, 1 << ERR_ROUTE, 1 << ERR_NO_SOM,
                    (1 << ERR_XCNT) | (1 << ERR_NO_EOM), 1 << ERR_NO_EOM};
  packet_header_and_starve_irq dut (
    .CLOCK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SOP_IN(sop), .EOP_IN(eop),
    .WORD_IN(word), .LAST_BYTES_IN(lb), .TX_IDLE_IN(idle),
    .WRITEBACK_DONE_IN(wbd), .STARVE_IN(starve), .ACCEPT_OUT(accept),
    .DROP_OUT(drop), .HALTED_OUT(halted), .FLOW_INDEX_OUT(flow),
    .DEST_TAG_OUT(dtag), .LOG_WRITE_OUT(logw), .LOG_DATA_OUT(logd),
    .STARVE_IRQ_OUT(sirq), .HALT_IRQ_OUT(hirq), .ERROR_IRQ_OUT(eirq));
  packet_dma_partner pdm (
    .clk_in(clk), .sop_out(sop), .eop_out(eop), .word_out(word),
    .last_bytes_out(lb), .tx_idle_out(idle), .wb_done_out(wbd),
    .starve_out(starve));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (logw === 1'b1)
      last_log <= logd;
  end
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [3:0] irq_of(input int s, input int r);
    irq_of = 4'h0;
    for (int i = 0; i < 8; i++)
      if (s[i]) irq_of |= r[4*i +: 4];
  endfunction : irq_of
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_wr_rd(input bit w, input logic [7:0] a1,
                           input logic [31:0] d, input logic [7:0] a2);
    if (w)
      reg_wr(a1, d);
    else
      @(posedge clk);
    rd <= 1'b1;
    addr <= a2;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : reg_wr_rd
  task automatic reg_rd(input logic [7:0] a);
    reg_wr_rd(1'b0, a, 32'h0000_0000, a);
  endtask : reg_rd
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({accept, drop, halted, hirq, eirq, sirq}, 32'h0000_0100);
    reg_rd(OFF_STARVE_STATUS);
    check(v, 0);
    reg_rd(OFF_IRQ_ROUTING);
    check(v, 0);
    reg_rd(8'hFC);
    check(v, 0);
    reg_rd(OFF_CONTROL);
    check(v[6:4], 3'h1);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      rt_m = rnd();
      reg_wr_rd(1'b1, OFF_IRQ_ROUTING, rt_m, OFF_IRQ_ROUTING);
      check(v, rt_m);
      m = rnd() & 255;
      st_m |= m;
      reg_wr_rd(1'b1, OFF_STARVE_FORCE, m, OFF_STARVE_STATUS);
      check(v, st_m);
      check(sirq, irq_of(st_m, rt_m));
      m = rnd();
      st_m &= ~m;
      reg_wr_rd(1'b1, OFF_STARVE_CLEAR, m, OFF_STARVE_STATUS);
      check(v, st_m);
      reg_wr_rd(1'b1, OFF_STARVE_STATUS, 32'hFF, OFF_STARVE_STATUS);
      check(v, st_m);
      check(sirq, irq_of(st_m, rt_m));
    end
    $display("test force and clear done");
    reg_wr(OFF_STARVE_CLEAR, 32'h0000_00FF);
    reg_wr(OFF_ERROR_STATUS, 32'h0000_00FF);
    reg_wr(OFF_CONTROL, 32'h0000_0004);
    pdm.starve(5);
    repeat (6) @(negedge clk);
    reg_rd(OFF_STARVE_STATUS);
    check(v, 32'h0000_0020);
    check(sirq, irq_of(32'h20, rt_m));
    reg_rd(OFF_ERROR_STATUS);
    check(v & 32'h0000_00F8, 32'h0000_0080);
    check(eirq, 1);
    reg_wr(OFF_ERROR_STATUS, 32'h0000_00FF);
    reg_rd(OFF_ERROR_STATUS);
    check(v, 0);
    check(eirq, 0);
    $display("test hardware starvation done");
    reg_wr(OFF_CONTROL, 32'h0000_000C);
    for (int k = 0; k < 4; k++) begin
      m = rnd();
      tg = rnd();
      pdm.send(pdm.mk(m[5:0], radio[k], 3'h0, k[1:0], tg, 4'h1), 5'h10);
      repeat (4) @(negedge clk);
      check(flow, m[5:0]);
      check(dtag, tg[15:0]);
      check({drop, accept}, 2'h1);
      check(last_log, tg);
    end
    reg_rd(OFF_ERROR_STATUS);
    check(v & 32'h0000_00F8, 0);
    $display("test packets done");
    reg_wr(OFF_CONTROL, 32'h0000_0004);
    for (int k = 0; k < 5; k++) begin
      pdm.send(pdm.mk(6'h00, 3'h0, 3'h0, e_ty[k], 0, e_md[k]), e_lb[k]);
      repeat (4) @(negedge clk);
      reg_rd(OFF_ERROR_STATUS);
      check(v & 32'h0000_00F8, e_err[k]);
      check(eirq, 1);
      reg_wr(OFF_ERROR_STATUS, 32'h0000_00FF);
    end
    $display("test errors done");
    pdm.send(pdm.mk(6'h05, 3'h0, 3'h3, 2'h0, 0, 4'h1), 5'h10);
    repeat (2) @(negedge clk);
    check({drop, accept}, 2'h2);
    pdm.wb_done((rnd() & 7) + 1);
    repeat (3) @(negedge clk);
    check(accept, 1);
    $display("test flush done");
    pdm.send(pdm.mk(6'h06, 3'h0, 3'h4, 2'h0, 0, 4'h1), 5'h10);
    repeat (6) @(negedge clk);
    check({halted, hirq, accept}, 3'h6);
    reg_rd(OFF_CONTROL);
    check(v[6:4], 3'h4);
    reg_wr(OFF_CONTROL, 32'h0000_0001);
    repeat (2) @(negedge clk);
    check({halted, hirq, accept}, 3'h1);
    $display("test halt done");
    close_out();
  end
endmodule : packet_header_and_starve_irq_bench
